// ---- bpr_consts.svh ----
// Register offsets, field positions and reset values of the transfer parameter bank.
// Assumes inclusion by the register bank module only.
`ifndef BPR_CONSTS_SVH
`define BPR_CONSTS_SVH

`define BPR_ADDR_W          8
`define BPR_OFF_SRC_Y_HIGH  8'h57
`define BPR_OFF_DST_X_LOW   8'h58
`define BPR_OFF_DST_X_HIGH  8'h59
`define BPR_OFF_DST_Y_LOW   8'h5A
`define BPR_OFF_DST_Y_HIGH  8'h5B
`define BPR_OFF_WIDTH_LOW   8'h5C
`define BPR_OFF_WIDTH_HIGH  8'h5D
`define BPR_OFF_HEIGHT_LOW  8'h5E
`define BPR_OFF_HEIGHT_HIGH 8'h5F
`define BPR_OFF_BACK_RED    8'h60
`define BPR_OFF_BACK_GREEN  8'h61
`define BPR_OFF_BACK_BLUE   8'h62
`define BPR_OFF_FORE_RED    8'h63
`define BPR_OFF_FORE_GREEN  8'h64
`define BPR_OFF_FORE_BLUE   8'h65
`define BPR_OFF_PATTERN     8'h66
`define BPR_OFF_KEY_RED     8'h67
`define BPR_OFF_KEY_GREEN   8'h68
`define BPR_OFF_KEY_BLUE    8'h69

`define BPR_LAYER_BIT       7
`define BPR_PAT_SIZE_BIT    7
`define BPR_HIGH2_MASK      8'h03
`define BPR_HIGH1_MASK      8'h01
`define BPR_LAYER_MASK      8'h81
`define BPR_PAT_MASK        8'h8F
`define BPR_RB_MASK         8'h1F
`define BPR_G_MASK          8'h3F

`define BPR_RST_ZERO        8'h00
`define BPR_RST_FORE_RB     8'h1F
`define BPR_RST_FORE_G      8'h3F

`endif

// ---- bpr_pkg.sv ----
// Types shared by the transfer parameter bank and its users.
// Assumes it is compiled before every module that uses its types.
package bpr_pkg;

   // Host register port request.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bpr_req_s;

   // Colour as the engine consumes it, already trimmed to the colour depth.
   typedef struct packed {
      logic [4:0] red;
      logic [5:0] green;
      logic [4:0] blue;
   } bpr_color_s;

   // Geometry and selects handed to the transfer engine.
   typedef struct packed {
      logic       src_layer;
      logic [8:0] src_y_msb_only;
      logic       dst_layer;
      logic [9:0] dst_x;
      logic [8:0] dst_y;
      logic [9:0] width;
      logic [9:0] height;
      logic       pattern_large;
      logic [3:0] pattern_set;
   } bpr_geom_s;

   // All stored registers of the bank.
   typedef struct packed {
      logic [1:0] sync;
      logic [7:0] src_y_high_layer;
      logic [7:0] dst_x_low;
      logic [7:0] dst_x_high;
      logic [7:0] dst_y_low;
      logic [7:0] dst_y_high_layer;
      logic [7:0] xfer_width_low;
      logic [7:0] xfer_width_high;
      logic [7:0] xfer_height_low;
      logic [7:0] xfer_height_high;
      logic [7:0] back_color_red;
      logic [7:0] back_color_green;
      logic [7:0] back_color_blue;
      logic [7:0] fore_color_red;
      logic [7:0] fore_color_green;
      logic [7:0] fore_color_blue;
      logic [7:0] pattern_select;
      logic [7:0] key_color_red;
      logic [7:0] key_color_green;
      logic [7:0] key_color_blue;
      logic [7:0] rdata;
      logic       depth_65k;
      bpr_geom_s  geom;
      bpr_color_s back;
      bpr_color_s fore;
      bpr_color_s key;
      logic       key_match;
   } bpr_state_s;

endpackage

// ---- bpr_param_regs.sv ----
// Configuration register bank of the block transfer engine, with trimmed outputs.
// Assumes a host port on ref_clk; colour depth, window pixel and key enable come from
// logic on the same clock.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`include "bpr_consts.svh"

module bpr_param_regs (
   input  wire logic               ref_clk,
   input  wire logic               rst_b,
   input  wire bpr_pkg::bpr_req_s  req,
   input  wire logic               depth_65k,
   input  wire logic               key_enable,
   input  wire bpr_pkg::bpr_color_s window_pixel,
   output logic [7:0]              rdata,
   output bpr_pkg::bpr_geom_s      geom,
   output bpr_pkg::bpr_color_s     back_color,
   output bpr_pkg::bpr_color_s     fore_color,
   output bpr_pkg::bpr_color_s     key_color,
   output logic                    key_match
);

   // ************************************************************
   // Helper functions
   // ************************************************************

   // Trims a stored colour to the bits the current depth uses.
   function automatic bpr_pkg::bpr_color_s trim_color(
      input logic [7:0] r,
      input logic [7:0] g,
      input logic [7:0] b,
      input logic       full
   );
      bpr_pkg::bpr_color_s c;
      if (full) begin
         c.red   = r[4:0];
         c.green = g[5:0];
         c.blue  = b[4:0];
      end else begin
         c.red   = {2'h0, r[2:0]};
         c.green = {3'h0, g[2:0]};
         c.blue  = {3'h0, b[1:0]};
      end
      return c;
   endfunction

   // Writes only the implemented bits of a register.
   function automatic logic [7:0] masked(
      input logic [7:0] d,
      input logic [7:0] m
   );
      return d & m;
   endfunction

   // ************************************************************
   // State
   // ************************************************************

   bpr_pkg::bpr_state_s st;
   bpr_pkg::bpr_state_s next_st;
   logic                rst_sync_b;

   assign rst_sync_b = st.sync[1];

   always_comb begin
      next_st      = st;
      next_st.sync = {st.sync[0], 1'b1};

      if (req.wr) begin
         unique case (req.addr)
            `BPR_OFF_SRC_Y_HIGH: begin
               next_st.src_y_high_layer = masked(req.wdata, `BPR_LAYER_MASK);
            end
            `BPR_OFF_DST_X_LOW: begin
               next_st.dst_x_low = req.wdata;
            end
            `BPR_OFF_DST_X_HIGH: begin
               next_st.dst_x_high = masked(req.wdata, `BPR_HIGH2_MASK);
            end
            `BPR_OFF_DST_Y_LOW: begin
               next_st.dst_y_low = req.wdata;
            end
            `BPR_OFF_DST_Y_HIGH: begin
               next_st.dst_y_high_layer = masked(req.wdata, `BPR_LAYER_MASK);
            end
            `BPR_OFF_WIDTH_LOW: begin
               next_st.xfer_width_low = req.wdata;
            end
            `BPR_OFF_WIDTH_HIGH: begin
               next_st.xfer_width_high = masked(req.wdata, `BPR_HIGH2_MASK);
            end
            `BPR_OFF_HEIGHT_LOW: begin
               next_st.xfer_height_low = req.wdata;
            end
            `BPR_OFF_HEIGHT_HIGH: begin
               next_st.xfer_height_high = masked(req.wdata, `BPR_HIGH2_MASK);
            end
            `BPR_OFF_BACK_RED: begin
               next_st.back_color_red = masked(req.wdata, `BPR_RB_MASK);
            end
            `BPR_OFF_BACK_GREEN: begin
               next_st.back_color_green = masked(req.wdata, `BPR_G_MASK);
            end
            `BPR_OFF_BACK_BLUE: begin
               next_st.back_color_blue = masked(req.wdata, `BPR_RB_MASK);
            end
            `BPR_OFF_FORE_RED: begin
               next_st.fore_color_red = masked(req.wdata, `BPR_RB_MASK);
            end
            `BPR_OFF_FORE_GREEN: begin
               next_st.fore_color_green = masked(req.wdata, `BPR_G_MASK);
            end
            `BPR_OFF_FORE_BLUE: begin
               next_st.fore_color_blue = masked(req.wdata, `BPR_RB_MASK);
            end
            `BPR_OFF_PATTERN: begin
               next_st.pattern_select = masked(req.wdata, `BPR_PAT_MASK);
            end
            `BPR_OFF_KEY_RED: begin
               next_st.key_color_red = masked(req.wdata, `BPR_RB_MASK);
            end
            `BPR_OFF_KEY_GREEN: begin
               next_st.key_color_green = masked(req.wdata, `BPR_G_MASK);
            end
            `BPR_OFF_KEY_BLUE: begin
               next_st.key_color_blue = masked(req.wdata, `BPR_RB_MASK);
            end
            default: begin
            end
         endcase
      end

      // Read data stands only in the cycle after the read strobe; unmapped reads give zero.
      next_st.rdata = `BPR_RST_ZERO;
      if (req.rd) begin
         unique case (req.addr)
            `BPR_OFF_SRC_Y_HIGH:  next_st.rdata = st.src_y_high_layer;
            `BPR_OFF_DST_X_LOW:   next_st.rdata = st.dst_x_low;
            `BPR_OFF_DST_X_HIGH:  next_st.rdata = st.dst_x_high;
            `BPR_OFF_DST_Y_LOW:   next_st.rdata = st.dst_y_low;
            `BPR_OFF_DST_Y_HIGH:  next_st.rdata = st.dst_y_high_layer;
            `BPR_OFF_WIDTH_LOW:   next_st.rdata = st.xfer_width_low;
            `BPR_OFF_WIDTH_HIGH:  next_st.rdata = st.xfer_width_high;
            `BPR_OFF_HEIGHT_LOW:  next_st.rdata = st.xfer_height_low;
            `BPR_OFF_HEIGHT_HIGH: next_st.rdata = st.xfer_height_high;
            `BPR_OFF_BACK_RED:    next_st.rdata = st.back_color_red;
            `BPR_OFF_BACK_GREEN:  next_st.rdata = st.back_color_green;
            `BPR_OFF_BACK_BLUE:   next_st.rdata = st.back_color_blue;
            `BPR_OFF_FORE_RED:    next_st.rdata = st.fore_color_red;
            `BPR_OFF_FORE_GREEN:  next_st.rdata = st.fore_color_green;
            `BPR_OFF_FORE_BLUE:   next_st.rdata = st.fore_color_blue;
            `BPR_OFF_PATTERN:     next_st.rdata = st.pattern_select;
            `BPR_OFF_KEY_RED:     next_st.rdata = st.key_color_red;
            `BPR_OFF_KEY_GREEN:   next_st.rdata = st.key_color_green;
            `BPR_OFF_KEY_BLUE:    next_st.rdata = st.key_color_blue;
            default:              next_st.rdata = `BPR_RST_ZERO;
         endcase
      end

      // ************************************************************
      // Engine-facing values, joined from the current bytes
      // ************************************************************
      next_st.depth_65k          = depth_65k;
      next_st.geom.src_layer     = st.src_y_high_layer[`BPR_LAYER_BIT];
      next_st.geom.src_y_msb_only = {st.src_y_high_layer[0], 8'h00};
      next_st.geom.dst_layer     = st.dst_y_high_layer[`BPR_LAYER_BIT];
      next_st.geom.dst_x         = {st.dst_x_high[1:0], st.dst_x_low};
      next_st.geom.dst_y         = {st.dst_y_high_layer[0], st.dst_y_low};
      next_st.geom.width         = {st.xfer_width_high[1:0], st.xfer_width_low};
      next_st.geom.height        = {st.xfer_height_high[1:0], st.xfer_height_low};
      next_st.geom.pattern_large = st.pattern_select[`BPR_PAT_SIZE_BIT];
      next_st.geom.pattern_set   = st.pattern_select[`BPR_PAT_SIZE_BIT]
                                   ? {2'h0, st.pattern_select[1:0]}
                                   : st.pattern_select[3:0];
      next_st.back = trim_color(st.back_color_red, st.back_color_green,
                                st.back_color_blue, depth_65k);
      next_st.fore = trim_color(st.fore_color_red, st.fore_color_green,
                                st.fore_color_blue, depth_65k);
      next_st.key  = trim_color(st.key_color_red, st.key_color_green,
                                st.key_color_blue, depth_65k);
      next_st.key_match = key_enable &&
                          (trim_color({3'h0, window_pixel.red}, {2'h0, window_pixel.green},
                                      {3'h0, window_pixel.blue}, depth_65k)
                           == trim_color(st.key_color_red, st.key_color_green,
                                         st.key_color_blue, depth_65k));
   end

   // ************************************************************
   // Registers
   // ************************************************************

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         st      <= '0;
      end else if (!rst_sync_b) begin
         st                  <= '0;
         st.sync             <= next_st.sync;
         st.fore_color_red   <= `BPR_RST_FORE_RB;
         st.fore_color_green <= `BPR_RST_FORE_G;
         st.fore_color_blue  <= `BPR_RST_FORE_RB;
      end else begin
         st <= next_st;
      end
   end

   assign rdata      = st.rdata;
   assign geom       = st.geom;
   assign back_color = st.back;
   assign fore_color = st.fore;
   assign key_color  = st.key;
   assign key_match  = st.key_match;

endmodule

// ---- bpr_param_regs_asserts.sv ----
// Checker for the transfer parameter bank, bound to the bank's ports.
// Assumes the host makes no request before the third edge after reset release.
`timescale 1ns/10ps
module bpr_param_regs_asserts (
   input wire logic                ref_clk,
   input wire logic                rst_b,
   input wire bpr_pkg::bpr_req_s   req,
   input wire logic                depth_65k,
   input wire logic                key_enable,
   input wire bpr_pkg::bpr_color_s window_pixel,
   input wire logic [7:0]          rdata,
   input wire bpr_pkg::bpr_geom_s  geom,
   input wire bpr_pkg::bpr_color_s back_color,
   input wire bpr_pkg::bpr_color_s fore_color,
   input wire bpr_pkg::bpr_color_s key_color,
   input wire logic                key_match
);
   logic [7:0] wd_q1;
   logic [7:0] wd_q2;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   // Write data two cycles back, the moment derived outputs show a write.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wd_q1 <= 8'h00;
         wd_q2 <= 8'h00;
      end else begin
         wd_q1 <= req.wdata;
         wd_q2 <= wd_q1;
      end
   end
   sequence wr_at(logic [7:0] a);
      req.wr && req.addr == a;
   endsequence
   src_layer_a: assert property (
      wr_at(8'h57) |-> ##2 geom.src_layer == wd_q2[7] && geom.src_y_msb_only == {wd_q2[0], 8'h00})
      else $error("source select wrong");
   dst_layer_a: assert property (
      wr_at(8'h5B) |-> ##2 geom.dst_layer == wd_q2[7] && geom.dst_y[8] == wd_q2[0])
      else $error("destination select wrong");
   dst_x_low_a: assert property (wr_at(8'h58) |-> ##2 geom.dst_x[7:0] == wd_q2)
      else $error("destination x low wrong");
   width_high_a: assert property (wr_at(8'h5D) |-> ##2 geom.width[9:8] == wd_q2[1:0])
      else $error("width high wrong");
   height_high_a: assert property (wr_at(8'h5F) |-> ##2 geom.height[9:8] == wd_q2[1:0])
      else $error("height high wrong");
   pattern_set_a: assert property (
      wr_at(8'h66) |-> ##2 geom.pattern_large == wd_q2[7]
      && geom.pattern_set == (wd_q2[7] ? {2'b00, wd_q2[1:0]} : wd_q2[3:0]))
      else $error("pattern select wrong");
   read_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
      else $error("read data outside read cycle");
   unmapped_read_a: assert property (
      req.rd && (req.addr < 8'h57 || req.addr > 8'h69) |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   depth_trim_a: assert property (
      !$past(depth_65k) |-> fore_color.red[4:3] == 2'h0 && fore_color.green[5:3] == 3'h0
      && fore_color.blue[4:2] == 3'h0) else $error("colour not trimmed");
   key_off_a: assert property (!$past(key_enable) |-> !key_match)
      else $error("key match while disabled");
endmodule

// ---- bpr_host_model.sv ----
// Host model driving the register port of the transfer parameter bank.
// Assumes read data stand in the cycle after the read strobe.
`timescale 1ns/10ps
module bpr_host_model (
   input  wire logic        ref_clk,
   input  wire logic [7:0]  rdata,
   output bpr_pkg::bpr_req_s req
);
   initial req = '0;
   // Idle address and data are inverted so stale values never look valid.
   task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      req <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
   endtask
   task automatic bus_read(input logic [7:0] addr, output logic [7:0] data);
      @(posedge ref_clk);
      req <= '{addr: addr, wdata: 8'h5A, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      req <= '{addr: ~addr, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
      #1;
      data = rdata;
   endtask
endmodule

// ---- test_bpr_param_regs.sv ----
// Self-checking testbench of the transfer parameter bank.
// Assumes the package, the bank, the checker and the host model are compiled first.
`timescale 1ns/10ps
module test_bpr_param_regs;
   logic                ref_clk;
   logic                rst_b;
   bpr_pkg::bpr_req_s   req;
   logic                depth_65k;
   logic                key_enable;
   bpr_pkg::bpr_color_s window_pixel;
   logic [7:0]          rdata;
   bpr_pkg::bpr_geom_s  geom;
   bpr_pkg::bpr_color_s back_color;
   bpr_pkg::bpr_color_s fore_color;
   bpr_pkg::bpr_color_s key_color;
   logic                key_match;
   int                  n_errors = 0;
   int                  samples_checked = 0;
   localparam logic [7:0] MASK [19] = '{8'h81, 8'hFF, 8'h03, 8'hFF, 8'h81, 8'hFF, 8'h03,
      8'hFF, 8'h03, 8'h1F, 8'h3F, 8'h1F, 8'h1F, 8'h3F, 8'h1F, 8'h8F, 8'h1F, 8'h3F, 8'h1F};

   bpr_host_model bpr_host_model_i (.ref_clk(ref_clk), .rdata(rdata), .req(req));
   bpr_param_regs bpr_param_regs_i (.ref_clk(ref_clk), .rst_b(rst_b), .req(req),
      .depth_65k(depth_65k), .key_enable(key_enable), .window_pixel(window_pixel),
      .rdata(rdata), .geom(geom), .back_color(back_color), .fore_color(fore_color),
      .key_color(key_color), .key_match(key_match));

   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      if (n_errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic settle();
      repeat (3) @(posedge ref_clk);
      #1;
   endtask
   task automatic reset_values();
      logic [7:0] d;
      for (int i = 0; i < 19; i++) begin
         bpr_host_model_i.bus_read(8'h57 + 8'(i), d);
         check("reset value", d, (i >= 12 && i <= 14) ? MASK[i] & 8'h3F : 8'h00);
      end
      check("fore colour", fore_color, 16'hFFFF);
   endtask
   task automatic masks_and_geometry();
      logic [7:0] d;
      for (int i = 0; i < 20; i++) bpr_host_model_i.bus_write(8'h57 + 8'(i), 8'hFF);
      for (int i = 0; i < 19; i++) begin
         bpr_host_model_i.bus_read(8'h57 + 8'(i), d);
         check("read mask", d, MASK[i]);
      end
      bpr_host_model_i.bus_read(8'h6A, d);
      check("unmapped high", d, 8'h00);
      bpr_host_model_i.bus_read(8'h56, d);
      check("unmapped low", d, 8'h00);
      check("geometry", geom, {1'b1, 9'h100, 1'b1, 10'h3FF, 9'h1FF,
         10'h3FF, 10'h3FF, 1'b1, 4'h3});
      check("background 65K", back_color, 16'hFFFF);
   endtask
   task automatic pattern_and_order();
      bpr_host_model_i.bus_write(8'h66, 8'h0A);
      bpr_host_model_i.bus_write(8'h59, 8'h02);
      bpr_host_model_i.bus_write(8'h58, 8'h34);
      settle();
      check("pattern size", geom.pattern_large, 1'b0);
      check("pattern set", geom.pattern_set, 4'hA);
      check("destination x", geom.dst_x, 10'h234);
   endtask
   task automatic colour_depth();
      @(posedge ref_clk);
      depth_65k <= 1'b0;
      settle();
      check("background 256", back_color, {5'h07, 6'h07, 5'h03});
      check("foreground 256", fore_color, {5'h07, 6'h07, 5'h03});
      @(posedge ref_clk);
      depth_65k <= 1'b1;
   endtask
   task automatic key_compare();
      bpr_host_model_i.bus_write(8'h67, 8'h05);
      bpr_host_model_i.bus_write(8'h68, 8'h2A);
      bpr_host_model_i.bus_write(8'h69, 8'h11);
      @(posedge ref_clk);
      key_enable <= 1'b1;
      window_pixel <= {5'h05, 6'h12, 5'h11};
      settle();
      check("key 65K", key_match, 1'b0);
      check("key colour", key_color, {5'h05, 6'h2A, 5'h11});
      @(posedge ref_clk);
      depth_65k <= 1'b0;
      settle();
      check("key 256", key_match, 1'b1);
      @(posedge ref_clk);
      key_enable <= 1'b0;
      settle();
      check("key disabled", key_match, 1'b0);
   endtask
   task automatic mid_reset();
      logic [7:0] d;
      bpr_host_model_i.bus_write(8'h64, 8'h05);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      bpr_host_model_i.bus_read(8'h64, d);
      check("fore green after reset", d, 8'h3F);
      bpr_host_model_i.bus_read(8'h67, d);
      check("key red after reset", d, 8'h00);
      check("geometry after reset", geom, 55'h0);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      rst_b = 1'b0;
      depth_65k = 1'b1;
      key_enable = 1'b0;
      window_pixel = '0;
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset_values();
      masks_and_geometry();
      pattern_and_order();
      colour_depth();
      key_compare();
      mid_reset();
      results();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      n_errors++;
      results();
   end
endmodule

bind bpr_param_regs bpr_param_regs_asserts bpr_param_regs_asserts_i (.ref_clk(ref_clk),
   .rst_b(rst_b), .req(req), .depth_65k(depth_65k), .key_enable(key_enable),
   .window_pixel(window_pixel), .rdata(rdata), .geom(geom), .back_color(back_color),
   .fore_color(fore_color), .key_color(key_color), .key_match(key_match));
